// >>> core/brac_top.sv
`include "brac_params.svh"
`default_nettype none
module brac_top (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RST,
    // core side
    input  wire logic                  BUS_REQ,
    input  wire logic                  DIFF_CLK_MODE,
    output logic                       AGENT_ID,
    output logic                       AGENT_ID_VALID,
    // request pins, open drain, active low
    input  wire brac_pkg::brac_req_pins_t REQ_PINS_IN,
    output logic                       BUS_REQUEST_PIN_A_OUT,
    output logic                       BUS_REQUEST_PIN_A_OE,
    output logic                       BUS_REQUEST_PIN_B_OUT,
    output logic                       BUS_REQUEST_PIN_B_OE,
    // configuration
    output logic [1:0]                 BUS_FREQ_SELECT,
    input  wire logic                  PLL_REFERENCE_INPUT,
    output logic                       BCLK_COMPLEMENT,
    output logic                       SOCKET_PRESENCE_OUT_N,
    // other agent's request seen on our pin b
    output logic                       PEER_REQ
);
    // request pin positions in the per pin vectors
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PINS  = 2;

    // synchroniser word: request pins above, pll reference in bit 0
    logic [2:0]               sync_d;
    logic [2:0]               sync_q;
    brac_pkg::brac_req_pins_t pins_s;
    logic                     ref_s;

    // id capture
    logic                     rst_d_r;
    logic                     capture;
    logic                     id_r;
    logic                     id_nxt;
    logic                     valid_r;
    logic                     valid_nxt;

    // request pins, open drain
    logic [PINS-1:0]          drive_r;
    logic [PINS-1:0]          drive_nxt;
    logic [PINS-1:0]          pin_out;

    // other agent's request
    logic                     peer_r;
    logic                     peer_nxt;

    // differential clock
    logic                     ref_r;
    logic                     ref_nxt;

    // pins and pll reference come from outside the clock domain
    assign sync_d = {REQ_PINS_IN, PLL_REFERENCE_INPUT};

    brac_sync #(
        .W (3)
    ) u_sync (
        .clk (CLK),
        .d   (sync_d),
        .q   (sync_q)
    );

    assign pins_s = sync_q[2:1];
    assign ref_s  = sync_q[0];

    // reset seen one edge late marks the first edge after release
    always_ff @(posedge CLK) begin
        rst_d_r <= RST;
    end

    assign capture = rst_d_r & ~RST;

    // capture on release
    // pin a level held by the central agent is through the sync by now
    always_comb begin
        id_nxt    = id_r;
        valid_nxt = valid_r;
        if (capture) begin
            id_nxt    = pins_s.pin_a_n;
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            id_r    <= `BRAC_ID_RESET;
            valid_r <= 1'b0;
        end else begin
            id_r    <= id_nxt;
            valid_r <= valid_nxt;
        end
    end

    // pin b is the other agent's line in our rotation
    always_comb begin
        drive_nxt        = '0;
        drive_nxt[PIN_A] = BUS_REQ & valid_r;
        drive_nxt[PIN_B] = 1'b0;
    end

    // open drain per pin: only ever pulls the wire low
    generate
        for (genvar gi = 0; gi < PINS; gi++) begin : g_pin
            always_ff @(posedge CLK) begin
                if (RST) begin
                    drive_r[gi] <= 1'b0;
                end else begin
                    drive_r[gi] <= drive_nxt[gi];
                end
            end

            assign pin_out[gi] = 1'b0;
        end
    endgenerate

    // other agent's request on pin b
    // ignored until the id is known, so a pin b held in reset is not a request
    assign peer_nxt = valid_r & ~pins_s.pin_b_n;

    always_ff @(posedge CLK) begin
        if (RST) begin
            peer_r <= 1'b0;
        end else begin
            peer_r <= peer_nxt;
        end
    end

    // differential clock
    // one clock domain only, so the complement is sampled, not used as a clock
    assign ref_nxt = DIFF_CLK_MODE & ~ref_s;

    always_ff @(posedge CLK) begin
        if (RST) begin
            ref_r <= 1'b0;
        end else begin
            ref_r <= ref_nxt;
        end
    end

    assign AGENT_ID              = id_r;
    assign AGENT_ID_VALID        = valid_r;
    assign BUS_REQUEST_PIN_A_OUT = pin_out[PIN_A];
    assign BUS_REQUEST_PIN_A_OE  = drive_r[PIN_A];
    assign BUS_REQUEST_PIN_B_OUT = pin_out[PIN_B];
    assign BUS_REQUEST_PIN_B_OE  = drive_r[PIN_B];

    assign BUS_FREQ_SELECT       = `BRAC_FREQ_SEL_133;
    assign BCLK_COMPLEMENT       = ref_r;

    // a core in the socket pulls presence low
    assign SOCKET_PRESENCE_OUT_N = 1'b0;
    assign PEER_REQ              = peer_r;
endmodule : brac_top
`default_nettype wire

// >>> core/brac_params.svh
// Overview of operation
// - request line 0 joins agent 0 pin a and agent 1 pin b, line 1 the opposite pair.
// - the level on pin a is captured when reset releases and kept as the agent id.
// - a bus request from the core is driven on pin a once the id is captured, whatever line it meets.
// - after the id is captured each agent drives pin a and only samples pin b, the same for either id.
// - the two-bit frequency select output shows 11 for the only supported 133 MHz bus.
// - every agent on the bus runs at one common bus frequency.
// - in differential clock mode the complement bus clock output is the pll reference input inverted.
`ifndef BRAC_PARAMS_SVH
`define BRAC_PARAMS_SVH

`define BRAC_FREQ_SEL_133    2'h3
`define BRAC_VID_TERMINATOR  5'h1f
`define BRAC_VID_W           5
`define BRAC_ID_RESET        1'h0

`endif

// >>> core/brac_pkg.sv
`default_nettype none
package brac_pkg;
    typedef enum logic [1:0] {
        BRAC_SOCKET_CORE,
        BRAC_SOCKET_TERM,
        BRAC_SOCKET_EMPTY
    } brac_socket_t;

    // pin levels are active low, as on the wire
    typedef struct packed {
        logic pin_a_n;
        logic pin_b_n;
    } brac_req_pins_t;
endpackage : brac_pkg
`default_nettype wire

// >>> core/brac_sync.sv
`include "brac_params.svh"
`default_nettype none
module brac_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // no reset: a level held through reset must already be through at release
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end
endmodule : brac_sync
`default_nettype wire

// >>> dv/brac_chk_assertions.sv
`default_nettype none
module brac_chk (
    input wire logic CLK, RST, BUS_REQ, DIFF_CLK_MODE, AGENT_ID, AGENT_ID_VALID, PEER_REQ,
    input wire brac_pkg::brac_req_pins_t REQ_PINS_IN,
    input wire logic BUS_REQUEST_PIN_A_OE, BUS_REQUEST_PIN_B_OE, BCLK_COMPLEMENT,
    input wire logic PLL_REFERENCE_INPUT,
    input wire logic [1:0] BUS_FREQ_SELECT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK);
    endclocking
    default disable iff RST;
    freq_fixed_a: assert property (BUS_FREQ_SELECT == 2'h3) else $error("freq");
    pin_b_idle_a: assert property (!BUS_REQUEST_PIN_B_OE) else $error("pin b");
    req_refused_a: assert property (!AGENT_ID_VALID |-> !BUS_REQUEST_PIN_A_OE)
        else $error("oe");
    req_follow_a: assert property ($past(AGENT_ID_VALID)
        |-> BUS_REQUEST_PIN_A_OE == $past(BUS_REQ)) else $error("req");
    id_capture_a: assert property ($fell(RST)
        |=> AGENT_ID_VALID && AGENT_ID == $past(REQ_PINS_IN.pin_a_n, 3)) else $error("id");
    id_hold_a: assert property (AGENT_ID_VALID |=> AGENT_ID_VALID && $stable(AGENT_ID))
        else $error("hold");
    bclk_comp_a: assert property (!$past(RST)
        |-> BCLK_COMPLEMENT == ($past(DIFF_CLK_MODE) && !$past(PLL_REFERENCE_INPUT, 3)))
        else $error("bclk");
    peer_seen_a: assert property (!$past(RST, 3) && !$past(RST, 2) && !$past(RST)
        |-> PEER_REQ == !$past(REQ_PINS_IN.pin_b_n, 3)) else $error("peer");
    cover property ($rose(BUS_REQUEST_PIN_A_OE));
    cover property ($fell(RST) ##1 AGENT_ID);
    cover property (PEER_REQ && BCLK_COMPLEMENT);
endmodule : brac_chk
bind brac_top brac_chk u_chk (.*);
`default_nettype wire

// >>> dv/brac_peer.sv
`default_nettype none
module brac_peer (
    input  wire logic RST, id_one, peer, BUS_REQUEST_PIN_A_OE,
    output var brac_pkg::brac_req_pins_t REQ_PINS_IN
);
    timeunit 1ns;
    timeprecision 1ns;
    // central agent pulls pin a low in reset for id 0
    // other agent requests on our pin b; released wires idle high
    assign REQ_PINS_IN = '{!(BUS_REQUEST_PIN_A_OE || (RST && !id_one)), !peer};
endmodule : brac_peer
`default_nettype wire

// >>> dv/testbench.sv
`include "brac_params.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RST = 1, BUS_REQ = 0, DIFF_CLK_MODE = 0, PLL_REFERENCE_INPUT = 0;
    logic AGENT_ID, AGENT_ID_VALID, BUS_REQUEST_PIN_A_OUT, BUS_REQUEST_PIN_A_OE;
    logic BUS_REQUEST_PIN_B_OUT, BUS_REQUEST_PIN_B_OE, BCLK_COMPLEMENT, SOCKET_PRESENCE_OUT_N;
    logic PEER_REQ, id_one = 0, peer = 0, rq = 0;
    logic [1:0] BUS_FREQ_SELECT;
    logic [2:0] pb = 3'h0, fh = 3'h0;
    logic [`BRAC_VID_W-1:0] vid = 5'h0;
    int error_cnt = 0, compares = 0, cyc = 0;
    brac_pkg::brac_req_pins_t REQ_PINS_IN;
    brac_top u_dut (.*);
    brac_peer u_peer (.*);
    always #5 CLK = ~CLK;
    function automatic logic exp_bclk(input logic m, r);
        return m & ~r;
    endfunction : exp_bclk
    // system side decode of presence and voltage id
    function automatic brac_pkg::brac_socket_t socket_of(input logic pres_n,
                                                        input logic [`BRAC_VID_W-1:0] v);
        if (pres_n) return brac_pkg::BRAC_SOCKET_EMPTY;
        if (v == `BRAC_VID_TERMINATOR) return brac_pkg::BRAC_SOCKET_TERM;
        return brac_pkg::BRAC_SOCKET_CORE;
    endfunction : socket_of
    task automatic chk(input logic [2:0] seen, exp);
        compares++;
        if (seen !== exp) $display("unexpected at %0t: %h %h", $time, seen, exp);
        if (seen !== exp) error_cnt++;
    endtask : chk
    task automatic conclude();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    always @(posedge CLK) if (++cyc > 999) begin
        error_cnt++;
        conclude();
    end
    initial begin
        void'($urandom(32'h8f0c));
        for (int t = 0; t < 2; t++) begin
            // second pass resets mid-run with the last bus request still standing
            id_one = t[0];
            DIFF_CLK_MODE = t[0];
            RST = 1;
            repeat (3) @(negedge CLK);
            RST = 0;
            @(negedge CLK);
            chk({AGENT_ID_VALID, AGENT_ID}, {1'b1, t[0]});
            chk({BUS_FREQ_SELECT, BUS_REQUEST_PIN_B_OE}, 3'h6);
            chk({BUS_REQUEST_PIN_A_OUT, BUS_REQUEST_PIN_B_OUT}, 3'h0);
            // requests standing through reset are refused at the release edge
            rq = 0;
            // pll reference stood still through reset
            fh = {3{PLL_REFERENCE_INPUT}};
            for (int n = 0; n < 300; n++) begin
                chk(BUS_REQUEST_PIN_A_OE, rq);
                chk(BCLK_COMPLEMENT, exp_bclk(t[0], fh[2]));
                chk(PEER_REQ, pb[2]);
                chk(socket_of(SOCKET_PRESENCE_OUT_N, vid), brac_pkg::BRAC_SOCKET_CORE);
                {BUS_REQ, PLL_REFERENCE_INPUT, peer} = 3'($urandom);
                vid = 5'($urandom % 31);
                {rq, fh, pb} = {BUS_REQ, fh[1:0], PLL_REFERENCE_INPUT, pb[1:0], peer};
                @(negedge CLK);
            end
            peer = 0;
            pb = 3'h0;
            $display("test %0d done", t);
        end
        conclude();
    end
endmodule : testbench
`default_nettype wire
